// [pkg/apc_pkg.sv]
package apc_pkg;

  localparam int WORD_W = 16;
  localparam int CNT_W  = 5;

  // Register select codes in the top bits of each serial word
  localparam int          SEL_LO   = 11;
  localparam logic [4:0]  CFG_SEL  = 5'h10;
  localparam logic [4:0]  MODE_SEL = 5'h00;

  // Configuration word fields
  localparam int REF_BIT   = 10;
  localparam int AVG_BIT   = 9;
  localparam int AVERAGE_COUNT_LO   = 7;
  localparam int REPEAT_RESULT_COUNT_LO  = 5;
  localparam int SPM_LO    = 3;

  // Mode control word fields
  localparam int PM_LO     = 2;
  localparam int SOFTWARE_CONVERT_BIT_BIT = 1;

  // Power field codes, shared by the static and automatic fields
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_FULL   = 2'h1;
  localparam logic [1:0] PWR_KEEP   = 2'h2;
  localparam logic [1:0] PWR_UNUSED = 2'h3;

  // Frames whose results are discarded after a chip-select wake
  localparam logic [1:0] WAKE_DISCARD = 2'h2;

  // Count decode bases
  localparam logic [5:0] AVG_BASE  = 6'h04;
  localparam logic [4:0] SCAN_STEP = 5'h04;
  localparam logic [5:0] ONE_CONV  = 6'h01;
  localparam logic [4:0] ONE_RES   = 5'h01;

  typedef struct packed {
    logic       ref_diff;
    logic       avg_en;
    logic [1:0] avg_cnt;
    logic [1:0] scan_cnt;
    logic [1:0] static_pwr;
  } apc_cfg_s;

  localparam apc_cfg_s CFG_RESET = '{1'b0, 1'b0, 2'h0, 2'h0, 2'h0};

  typedef struct packed {
    logic core_on;
    logic bias_on;
    logic ref_on;
  } apc_power_s;

  localparam apc_power_s POWER_ALL_ON = '{1'b1, 1'b1, 1'b1};

  typedef enum logic {PS_AWAKE, PS_AUTO_OFF} apc_pwr_state_e;

endpackage

// [rtl/apc_power_config.sv]
`timescale 1ns/1ns

// Overview of operation
// - Three power-down paths: static, automatic with external clock, automatic internal.
// - Static power field nonzero shuts down: full, or partial keeping bias and reference running.
// - External clock, automatic field set: power down at chip-select rise of next frame.
// - External clock: after automatic power-down, wake at next chip-select fall.
// - Internal clock, automatic field set: shut down once all conversions finish.
// - Internal clock: wake on convert-start fall, or frame setting software convert.
// - Automatic field: 00 normal, 01 full shutdown, 10 standby, 11 unused.
// - After chip-select wake, first two frames give no valid result; host discards.
// - Automatic shutdown and standby keep every register's contents.
// - Standby keeps only the bias generator on; full shutdown powers everything down.
// - Select code 10000 in bits 15:11 routes remaining bits to configuration fields.
// - Bit 10, reset 0: 0 single-ended reference, 1 differential reference.
// - Bit 9, reset 0: averaging enable, effective only with internal clock.
// - Bits 8:7 select 4, 8, 16 or 32 conversions averaged per result.
// - Averaging off: exactly one conversion per requested result.
// - Bits 6:5, reset 00: repeat scan result count, only in repeat mode.
// - Repeat codes 00..11 give 4, 8, 12, 16 results.
// - Bits 4:3, reset 00: normal, full, partial keeping reference; 11 unused.
module apc_power_config (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                din,
  input  wire logic                convert_start_pin_n,
  input  wire logic                ext_clock_mode,
  input  wire logic                repeat_mode,
  input  wire logic                conv_all_done,
  output apc_pkg::apc_cfg_s        cfg,
  output logic [1:0]               auto_power_field,
  output logic                     reference_source_select,
  output logic                     averaging_active,
  output logic [5:0]               conv_per_result,
  output logic [4:0]               repeat_result_count,
  output apc_pkg::apc_power_s      power,
  output logic                     powered_down,
  output logic                     discard_result,
  output logic                     software_convert_bit
);

  // Pin order in the synchroniser: {convert start, din, chip select, serial clock}
  logic [3:0]                    meta_reg;
  logic [3:0]                    sync_reg;
  logic [3:0]                    last_reg;
  logic [apc_pkg::WORD_W-1:0]    shift_reg;
  logic [apc_pkg::CNT_W-1:0]     bit_cnt_reg;
  apc_pkg::apc_cfg_s             cfg_reg;
  logic [1:0]                    auto_reg;
  logic [1:0]                    auto_next;
  logic                          armed_reg;
  apc_pkg::apc_pwr_state_e       state_reg;
  logic [1:0]                    discard_reg;
  logic                          software_convert_bit_reg;
  apc_pkg::apc_power_s           power_reg;
  logic                          averaging_reg;
  logic [5:0]                    conv_reg;
  logic [4:0]                    scan_reg;

  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic cnv_fall;
  logic word_full;
  logic cfg_write;
  logic mode_write;
  logic sw_wake;
  logic go_sleep;
  logic go_wake;

  // Pins are asynchronous to clk; the serial clock is only oversampled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 4'hf;
      sync_reg <= 4'hf;
      last_reg <= 4'hf;
    end else begin
      meta_reg <= {convert_start_pin_n, din, cs_n, sclk};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign cs_fall   = last_reg[1] & ~sync_reg[1];
  assign cs_rise   = ~last_reg[1] & sync_reg[1];
  assign sclk_rise = ~last_reg[0] & sync_reg[0] & ~sync_reg[1];
  assign cnv_fall  = last_reg[3] & ~sync_reg[3];

  // Serial word capture; bits beyond sixteen keep the last sixteen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[apc_pkg::WORD_W-2:0], sync_reg[2]};
      if (bit_cnt_reg != apc_pkg::CNT_W'(apc_pkg::WORD_W)) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // A short frame is dropped so that no field changes half-written
  assign word_full  = bit_cnt_reg == apc_pkg::CNT_W'(apc_pkg::WORD_W);
  assign cfg_write  = cs_rise & word_full &
                      (shift_reg[apc_pkg::WORD_W-1:apc_pkg::SEL_LO] == apc_pkg::CFG_SEL);
  assign mode_write = cs_rise & word_full &
                      (shift_reg[apc_pkg::WORD_W-1:apc_pkg::SEL_LO] == apc_pkg::MODE_SEL);

  // Configuration fields, applied together at the frame end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= apc_pkg::CFG_RESET;
    end else if (cfg_write) begin
      cfg_reg.ref_diff <= shift_reg[apc_pkg::REF_BIT];
      cfg_reg.avg_en   <= shift_reg[apc_pkg::AVG_BIT];
      cfg_reg.avg_cnt  <= shift_reg[apc_pkg::AVERAGE_COUNT_LO +: 2];
      cfg_reg.scan_cnt <= shift_reg[apc_pkg::REPEAT_RESULT_COUNT_LO +: 2];
      if (shift_reg[apc_pkg::SPM_LO +: 2] != apc_pkg::PWR_UNUSED) begin
        cfg_reg.static_pwr <= shift_reg[apc_pkg::SPM_LO +: 2];
      end
    end
  end

  always_comb begin
    auto_next = auto_reg;
    if (mode_write && shift_reg[apc_pkg::PM_LO +: 2] != apc_pkg::PWR_UNUSED) begin
      auto_next = shift_reg[apc_pkg::PM_LO +: 2];
    end
  end

  assign sw_wake = mode_write & shift_reg[apc_pkg::SOFTWARE_CONVERT_BIT_BIT];

  // The arm flag holds the setting from an earlier frame, so the setting
  // frame itself never powers down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_reg  <= apc_pkg::PWR_NORMAL;
      armed_reg <= 1'b0;
      software_convert_bit_reg <= 1'b0;
    end else begin
      auto_reg  <= auto_next;
      software_convert_bit_reg <= sw_wake;
      if (cs_rise) begin
        armed_reg <= auto_next != apc_pkg::PWR_NORMAL;
      end
    end
  end

  always_comb begin
    go_sleep = 1'b0;
    go_wake  = 1'b0;
    if (state_reg == apc_pkg::PS_AWAKE) begin
      if (ext_clock_mode) begin
        go_sleep = cs_rise & armed_reg & (auto_next != apc_pkg::PWR_NORMAL);
      end else begin
        go_sleep = conv_all_done & (auto_reg != apc_pkg::PWR_NORMAL);
      end
    end else begin
      if (ext_clock_mode) begin
        go_wake = cs_fall;
      end else begin
        go_wake = cnv_fall | sw_wake;
      end
      if (auto_next == apc_pkg::PWR_NORMAL) begin
        go_wake = 1'b1;
      end
    end
  end

  // Only analog enables drop; every register above keeps its value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= apc_pkg::PS_AWAKE;
    end else begin
      unique case (state_reg)
        apc_pkg::PS_AWAKE: begin
          if (go_sleep) begin
            state_reg <= apc_pkg::PS_AUTO_OFF;
          end
        end
        apc_pkg::PS_AUTO_OFF: begin
          if (go_wake) begin
            state_reg <= apc_pkg::PS_AWAKE;
          end
        end
      endcase
    end
  end

  // Counts frames, not clocks: each chip-select rise ends one conversion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      discard_reg <= 2'h0;
    end else if (cs_fall && ext_clock_mode && state_reg == apc_pkg::PS_AUTO_OFF) begin
      discard_reg <= apc_pkg::WAKE_DISCARD;
    end else if (cs_rise && discard_reg != 2'h0) begin
      discard_reg <= discard_reg - 2'h1;
    end
  end

  // Static shutdown overrides the automatic modes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_reg <= apc_pkg::POWER_ALL_ON;
    end else if (cfg_reg.static_pwr == apc_pkg::PWR_FULL) begin
      power_reg <= '{1'b0, 1'b0, 1'b0};
    end else if (cfg_reg.static_pwr == apc_pkg::PWR_KEEP) begin
      power_reg <= '{1'b0, 1'b1, 1'b1};
    end else if (state_reg == apc_pkg::PS_AUTO_OFF) begin
      power_reg <= '{1'b0, auto_reg == apc_pkg::PWR_KEEP, 1'b0};
    end else begin
      power_reg <= apc_pkg::POWER_ALL_ON;
    end
  end

  // Count decodes, registered for the conversion core
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      averaging_reg <= 1'b0;
      conv_reg      <= apc_pkg::ONE_CONV;
      scan_reg      <= apc_pkg::ONE_RES;
    end else begin
      averaging_reg <= cfg_reg.avg_en & ~ext_clock_mode;
      if (cfg_reg.avg_en && !ext_clock_mode) begin
        conv_reg <= apc_pkg::AVG_BASE << cfg_reg.avg_cnt;
      end else begin
        conv_reg <= apc_pkg::ONE_CONV;
      end
      if (repeat_mode) begin
        scan_reg <= apc_pkg::SCAN_STEP * (5'({3'h0, cfg_reg.scan_cnt}) + 5'h01);
      end else begin
        scan_reg <= apc_pkg::ONE_RES;
      end
    end
  end

  assign cfg                     = cfg_reg;
  assign auto_power_field        = auto_reg;
  assign reference_source_select = cfg_reg.ref_diff;
  assign averaging_active        = averaging_reg;
  assign conv_per_result         = conv_reg;
  assign repeat_result_count     = scan_reg;
  assign power                   = power_reg;
  assign powered_down            = state_reg == apc_pkg::PS_AUTO_OFF;
  assign discard_result          = discard_reg != 2'h0;
  assign software_convert_bit    = software_convert_bit_reg;

endmodule // apc_power_config

// [verif/apc_power_config_properties.sv]
`timescale 1ns/1ns
module apc_props (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              cs_n,
  input wire logic              convert_start_pin_n,
  input wire logic              ext_clock_mode,
  input wire logic              repeat_mode,
  input wire logic              conv_all_done,
  input wire apc_pkg::apc_cfg_s cfg,
  input wire logic [1:0]        auto_power_field,
  input wire logic              reference_source_select,
  input wire logic              averaging_active,
  input wire logic [5:0]        conv_per_result,
  input wire logic [4:0]        repeat_result_count,
  input wire apc_pkg::apc_power_s power,
  input wire logic              powered_down,
  input wire logic              discard_result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_cs_wake;
    ext_clock_mode && powered_down && $fell(cs_n);
  endsequence
  sequence s_woken;
    !powered_down && discard_result;
  endsequence
  property p_ref; $changed(reference_source_select) |->
    cs_n && $past(cs_n) && $past(cs_n, 2); endproperty
  a_ref: assert property (p_ref) else $error("reference select off");
  // Three stable cycles let the registered decodes settle
  property p_nconv; ($stable(cfg) && $stable(ext_clock_mode))[*3] |->
    conv_per_result == ((cfg.avg_en && !ext_clock_mode) ? 6'h04 << cfg.avg_cnt : 6'h01);
  endproperty
  a_nconv: assert property (p_nconv) else $error("conversion count off");
  property p_repeat_result_count; ($stable(cfg) && $stable(repeat_mode))[*3] |-> repeat_result_count ==
    (repeat_mode ? {cfg.scan_cnt, 2'h0} + 5'h04 : 5'h01); endproperty
  a_repeat_result_count: assert property (p_repeat_result_count) else $error("repeat count off");
  property p_static; ($stable(cfg.static_pwr) && cfg.static_pwr != 2'h0)[*2] |->
    power == {1'b0, cfg.static_pwr[1], cfg.static_pwr[1]}; endproperty
  a_static: assert property (p_static) else $error("static power off");
  property p_auto; (cfg.static_pwr == 2'h0 && powered_down && $stable(auto_power_field))[*2]
    |-> power == (auto_power_field == 2'h2 ? 3'h2 : 3'h0); endproperty
  a_auto: assert property (p_auto) else $error("auto power off");
  property p_on; (cfg.static_pwr == 2'h0 && !powered_down)[*2] |-> power == 3'h7; endproperty
  a_on: assert property (p_on) else $error("not fully powered");
  property p_wake; s_cs_wake |-> ##[1:6] s_woken; endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");
  property p_isleep;
    !ext_clock_mode && conv_all_done && auto_power_field != 2'h0 |=> powered_down;
  endproperty
  a_isleep: assert property (p_isleep) else $error("no internal sleep");
  property p_iwake; !ext_clock_mode && powered_down && $fell(convert_start_pin_n)
    |-> ##[1:6] !powered_down; endproperty
  a_iwake: assert property (p_iwake) else $error("no convert wake");
endmodule // apc_props

bind apc_power_config apc_props u_props (.*);

// [verif/apc_host.sv]
`timescale 1ns/1ns
module apc_host (
  input wire logic clk,
  output logic     sclk,
  output logic     cs_n,
  output logic     din
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end
  // Serial clock stands still outside frames
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din = w[15 - i];
      #80;
      sclk = 1'b1;
      #80;
    end
    #80;
    cs_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule // apc_host

// [verif/apc_power_config_test.sv]
`timescale 1ns/1ns
module apc_power_config_test;
  logic clk, nrst, ext_clock_mode, repeat_mode, conv_all_done, convert_start_pin_n;
  logic reference_source_select, averaging_active, powered_down, discard_result;
  logic software_convert_bit;
  wire  sclk, cs_n, din;
  logic [1:0]          auto_power_field;
  logic [5:0]          conv_per_result;
  logic [4:0]          repeat_result_count;
  apc_pkg::apc_cfg_s   cfg;
  apc_pkg::apc_power_s power;
  int failures, samples_checked, cycles, software_convert_bit_seen;
  apc_host u_host (.clk, .sclk, .cs_n, .din);
  apc_power_config u_dut (.clk, .nrst, .sclk, .cs_n, .din, .convert_start_pin_n,
    .ext_clock_mode, .repeat_mode, .conv_all_done, .cfg, .auto_power_field,
    .reference_source_select, .averaging_active, .conv_per_result, .repeat_result_count,
    .power, .powered_down, .discard_result, .software_convert_bit);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end
  always @(posedge clk) begin
    if (software_convert_bit === 1'b1) software_convert_bit_seen++;
  end
  task pulse_done;
    conv_all_done = 1'b1;
    tick(1);
    conv_all_done = 1'b0;
    tick(3);
  endtask
  task t_reset;
    check({cfg, power, powered_down}, {8'h00, 3'h7, 1'b0});
    check({conv_per_result, repeat_result_count}, {6'h01, 5'h04});
  endtask
  task t_cfg;
    for (int k = 0; k < 4; k++) begin
      u_host.send(16'(16'h8600 | (k << 7) | (k << 5)), 16);
      check({averaging_active, reference_source_select, conv_per_result, repeat_result_count},
        {2'h3, 6'h04 << k, 5'(4 * (k + 1))});
    end
    ext_clock_mode = 1'b1;
    repeat_mode = 1'b0;
    tick(4);
    check({averaging_active, conv_per_result, repeat_result_count}, 12'h021);
  endtask
  task t_refuse;
    u_host.send(16'h9800, 16);
    u_host.send(16'h8000, 12);
    check(cfg, 8'hfc);
    u_host.send(16'h8018, 16);
    check(cfg, 8'h00);
  endtask
  task t_static;
    u_host.send(16'h8008, 16);
    check(power, 3'h0);
    u_host.send(16'h8010, 16);
    check(power, 3'h3);
    u_host.send(16'h8400, 16);
    check(power, 3'h7);
  endtask
  task t_ext;
    u_host.send(16'h0008, 16);
    check(powered_down, 1'b0);
    u_host.send(16'h000c, 16);
    check({powered_down, auto_power_field, power, cfg}, {6'h32, 8'h80});
    u_host.send(16'h0000, 16);
    check({powered_down, discard_result, power}, 5'h0f);
    u_host.send(16'h0000, 16);
    check(discard_result, 1'b0);
  endtask
  task t_int;
    ext_clock_mode = 1'b0;
    u_host.send(16'h0004, 16);
    pulse_done();
    check({powered_down, power}, 4'h8);
    convert_start_pin_n = 1'b0;
    tick(4);
    convert_start_pin_n = 1'b1;
    tick(4);
    check(powered_down, 1'b0);
    pulse_done();
    u_host.send(16'h0006, 16);
    check({powered_down, discard_result}, 2'h0);
    check(software_convert_bit_seen, 1);
  endtask
  initial begin
    nrst = 1'b0;
    ext_clock_mode = 1'b0;
    repeat_mode = 1'b1;
    conv_all_done = 1'b0;
    convert_start_pin_n = 1'b1;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    software_convert_bit_seen = 0;
    tick(2);
    nrst = 1'b1;
    tick(4);
    t_reset();
    t_cfg();
    t_refuse();
    t_static();
    t_ext();
    t_int();
    wrap_up();
  end
endmodule // apc_power_config_test
